// *** sport_pkg.sv ***
// Package with addresses, reset values, field positions and timing constants of the serial port.
`default_nettype none
package sport_pkg;
  // Width of one conversion result.
  localparam int RESULT_W = 18;
  // Interface mode that turns the shared pins into serial port inputs.
  localparam logic [1:0] MODE_SERIAL = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // Register byte addresses on the AXI4-Lite port.
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Lowest result bit carried by the four shared pins in parallel modes.
  localparam int PAR_LO = 6;
  // Shared pin positions of the serial selects.
  localparam int PIN_CLK_SRC = 0;
  localparam int PIN_SYNC_POL = 1;
  localparam int PIN_CLK_INV = 2;
  localparam int PIN_RD_CHAIN = 3;
  // Serial clock periods before chained data reaches the serial output.
  localparam int CHAIN_DELAY = 18;
  // Internal serial clock timing, least half period.
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Master frame states, Gray coded from M_IDLE to M_END; the return from M_END to M_IDLE flips both bits.
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_SHIFT = 2'h1,
    M_END = 2'h3
  } mstate_type;
endpackage : sport_pkg
`default_nettype wire

// *** shift_if.sv ***
// Interface that joins a serial shift register to the logic that drives it.
`timescale 1ns/1ps
`default_nettype none
interface shift_if #(parameter int W = sport_pkg::RESULT_W);
  logic load;
  logic shift;
  logic [W-1:0] word;
  logic chain_in;
  logic dout;
  logic busy;
  modport ctl (output load, output shift, output word, output chain_in, input dout, input busy);
  modport shf (input load, input shift, input word, input chain_in, output dout, output busy);
endinterface : shift_if
`default_nettype wire

// *** serial_shifter.sv ***
// Result shift register that sends a word and then passes chained data.
`timescale 1ns/1ps
`default_nettype none
module serial_shifter #(parameter int W = sport_pkg::RESULT_W) (
  // Clock and synchronous reset of the owning domain.
  input wire logic clk,
  input wire logic rst_n,
  // Load, shift and data from the owner.
  shift_if.shf sp
);
  localparam int CW = $clog2(W + 1);

  typedef struct packed {
    logic [W-1:0] sreg;
    logic [CW-1:0] cnt;
    logic busy;
  } sh_type;

  sh_type sh_r;
  sh_type sh_nxt;

  // Load wins over shift so a new word never mixes with old bits.
  always_comb begin
    sh_nxt = sh_r;
    if (sp.load) begin
      sh_nxt.sreg = sp.word;
      sh_nxt.cnt = '0;
      sh_nxt.busy = 1'b1;
    end else if (sp.shift) begin
      // (R10) MSB leaves first.
      sh_nxt.sreg = {sh_r.sreg[W-2:0], sp.chain_in};
      if (sh_r.busy) begin
        sh_nxt.cnt = sh_r.cnt + CW'(1);
        sh_nxt.busy = (sh_r.cnt != CW'(W - 1));
      end
    end
    if (!rst_n) begin
      sh_nxt = '0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    sh_r <= sh_nxt;
  end

  assign sp.dout = sh_r.sreg[W-1];
  assign sp.busy = sh_r.busy;
endmodule : serial_shifter
`default_nettype wire

// *** adc_serial_port_pin_config.sv ***
// Shared pin and serial port configuration logic of the converter output interface.
//
// Overview of operation
// (R1) Outside serial mode the four shared pins drive result bits six to nine.
// (R2) In serial mode with the clock source low the block makes and drives the serial clock.
// (R3) In serial mode with the clock source high the host clocks and output follows that clock.
// (R4) The sync polarity select low gives an active high sync, high gives active low.
// (R5) The clock invert select inverts the serial clock in master and slave operation.
// (R6) The last shared pin is chained data with the clock source high, read mode with it low.
// (R7) With the external clock, chained data appears on the output 18 periods after the start.
// (R8) Internal clock: read mode high shifts during conversion, low waits for completion.
// (R9) External clock: output updates on the rising edge, or on the falling one when inverted.
// (R10) The result leaves the shift register most significant bit first.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_pin_config #(parameter int W = sport_pkg::RESULT_W) (
  // System clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [sport_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [sport_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Conversion engine.
  input wire logic [W-1:0] result_data,
  input wire logic result_valid,
  input wire logic conv_start,
  // Shared pins: bit 0 is parallel_bit_six, bit 3 is parallel_bit_nine.
  input wire logic [3:0] shared_in,
  output logic [3:0] shared_out,
  output logic [3:0] shared_oe,
  // Serial clock pin; its input is the link clock.
  input wire logic link_sclk,
  output logic sclk_out,
  output logic sclk_oe,
  // Frame sync and serial data.
  output logic sync_out,
  output logic serial_result_out
);
  localparam logic [7:0] HALF_LAST = 8'(sport_pkg::SCLK_HALF_CYC - 1);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic [sport_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic [W-1:0] result;
    logic [W-1:0] tx_word;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] par_out;
    logic [3:0] par_oe;
    sport_pkg::mstate_type mst;
    logic [7:0] div;
    logic phase;
    logic sclk_out;
    logic sclk_oe;
    logic sync_out;
    logic s_req;
    logic ack_meta;
    logic ack_sync;
  } sys_type;

  typedef struct packed {
    logic rst_meta;
    logic rst_n;
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic ack;
  } lnk_type;

  sys_type a_r;
  sys_type a_nxt;
  lnk_type l_r;
  lnk_type l_nxt;

  logic serial;
  logic clock_source_select;
  logic sync_polarity_select;
  logic serial_clock_invert;
  logic read_mode_or_chain_input;
  logic s_pending;
  logic sync_active;
  logic m_load;
  logic m_shift;
  logic [W-1:0] m_word;
  logic m_start;
  logic link_clk;
  logic s_load;

  shift_if #(.W(W)) m_if ();
  shift_if #(.W(W)) s_if ();

  // The selects are read only after the two-stage synchroniser.
  assign serial = (a_r.mode == sport_pkg::MODE_SERIAL);
  assign clock_source_select = a_r.pin_sync[sport_pkg::PIN_CLK_SRC];
  assign sync_polarity_select = a_r.pin_sync[sport_pkg::PIN_SYNC_POL];
  assign serial_clock_invert = a_r.pin_sync[sport_pkg::PIN_CLK_INV];
  assign read_mode_or_chain_input = a_r.pin_sync[sport_pkg::PIN_RD_CHAIN];
  assign s_pending = (a_r.s_req != a_r.ack_sync);
  assign sync_active = (a_r.mst == sport_pkg::M_SHIFT) || s_pending;
  // (R8) Read mode picks start event.
  assign m_start = read_mode_or_chain_input ? conv_start : result_valid;

  // System domain: register port, pin sampling, master clock and frame control.
  always_comb begin
    a_nxt = a_r;
    m_load = 1'b0;
    m_shift = 1'b0;
    // Read during conversion sends the previous result, otherwise the fresh one.
    m_word = read_mode_or_chain_input ? a_r.result : result_data;
    a_nxt.pin_meta = shared_in;
    a_nxt.pin_sync = a_r.pin_meta;
    a_nxt.ack_meta = l_r.ack;
    a_nxt.ack_sync = a_r.ack_meta;
    if (result_valid) begin
      a_nxt.result = result_data;
    end

    // Address and data are taken in either order; the write happens once both are held.
    if (awvalid && a_r.awready) begin
      a_nxt.aw_have = 1'b1;
      a_nxt.aw_addr = awaddr;
    end
    if (wvalid && a_r.wready) begin
      a_nxt.w_have = 1'b1;
      a_nxt.w_data = wdata;
      a_nxt.w_strb = wstrb;
    end
    if (a_r.bvalid && bready) begin
      a_nxt.bvalid = 1'b0;
    end
    if (a_nxt.aw_have && a_nxt.w_have && !a_r.bvalid) begin
      a_nxt.aw_have = 1'b0;
      a_nxt.w_have = 1'b0;
      a_nxt.bvalid = 1'b1;
      a_nxt.bresp = sport_pkg::RESP_OKAY;
      case (a_nxt.aw_addr)
        sport_pkg::ADDR_CTRL: begin
          if (a_nxt.w_strb[0]) begin
            a_nxt.mode = a_nxt.w_data[1:0];
          end
        end
        sport_pkg::ADDR_STATUS, sport_pkg::ADDR_RESULT: begin
          a_nxt.bresp = sport_pkg::RESP_OKAY;
        end
        default: begin
          a_nxt.bresp = sport_pkg::RESP_SLVERR;
        end
      endcase
    end
    a_nxt.awready = !a_nxt.aw_have && !a_nxt.bvalid;
    a_nxt.wready = !a_nxt.w_have && !a_nxt.bvalid;

    // Reads answer one cycle after the address is taken.
    if (a_r.rvalid && rready) begin
      a_nxt.rvalid = 1'b0;
    end
    if (arvalid && a_r.arready) begin
      a_nxt.rvalid = 1'b1;
      a_nxt.rresp = sport_pkg::RESP_OKAY;
      case (araddr)
        sport_pkg::ADDR_CTRL: begin
          a_nxt.rdata = {30'h0, a_r.mode};
        end
        sport_pkg::ADDR_STATUS: begin
          a_nxt.rdata = {24'h0, s_pending, sync_active, a_r.pin_sync, a_r.mode};
        end
        sport_pkg::ADDR_RESULT: begin
          a_nxt.rdata = 32'(a_r.result);
        end
        default: begin
          a_nxt.rdata = 32'h0;
          a_nxt.rresp = sport_pkg::RESP_SLVERR;
        end
      endcase
    end
    a_nxt.arready = !a_nxt.rvalid;

    // Master frame: the divider sets the internal serial clock.
    case (a_r.mst)
      sport_pkg::M_IDLE: begin
        a_nxt.div = 8'h0;
        a_nxt.phase = 1'b0;
        // (R2) Master starts own clock.
        if (serial && !clock_source_select && m_start) begin
          m_load = 1'b1;
          a_nxt.mst = sport_pkg::M_SHIFT;
        end
      end
      sport_pkg::M_SHIFT: begin
        if (a_r.div == HALF_LAST) begin
          a_nxt.div = 8'h0;
          a_nxt.phase = !a_r.phase;
          // Shifting at the falling edge keeps data steady around the rising edge.
          m_shift = a_r.phase;
        end else begin
          a_nxt.div = a_r.div + 8'h1;
        end
        if (!m_if.busy) begin
          a_nxt.mst = sport_pkg::M_END;
        end
      end
      sport_pkg::M_END: begin
        a_nxt.mst = sport_pkg::M_IDLE;
      end
      default: begin
        a_nxt.mst = sport_pkg::M_IDLE;
      end
    endcase
    // (R3) No master frame with external clock.
    if (!serial || clock_source_select) begin
      a_nxt.mst = sport_pkg::M_IDLE;
      m_load = 1'b0;
    end

    // (R3) Slave start request to link.
    if (serial && clock_source_select && result_valid && !s_pending) begin
      a_nxt.s_req = !a_r.s_req;
      a_nxt.tx_word = result_data;
    end

    // (R2) Drive clock only as master.
    a_nxt.sclk_oe = serial && !clock_source_select;
    // (R5) Inverted master clock.
    a_nxt.sclk_out = a_nxt.phase ^ serial_clock_invert;
    // (R4) Sync polarity select.
    a_nxt.sync_out = serial && (sync_active ^ sync_polarity_select);
    // (R1) Parallel bits six to nine.
    a_nxt.par_oe = serial ? 4'h0 : 4'hf;
    a_nxt.par_out = serial ? 4'h0 : a_r.result[sport_pkg::PAR_LO+3:sport_pkg::PAR_LO];

    if (!aresetn) begin
      a_nxt = '0;
      a_nxt.mode = sport_pkg::MODE_RESET;
      a_nxt.mst = sport_pkg::M_IDLE;
      m_load = 1'b0;
      m_shift = 1'b0;
    end
  end

  // System state register.
  always_ff @(posedge aclk) begin
    a_r <= a_nxt;
  end

  assign m_if.load = m_load;
  assign m_if.shift = m_shift;
  assign m_if.word = m_word;
  assign m_if.chain_in = 1'b0;

  serial_shifter #(.W(W)) master_shifter (
    .clk(aclk),
    .rst_n(aresetn),
    .sp(m_if)
  );

  // (R9) Inversion swaps the update edge.
  // The select is a static strap, so switching it mid-frame is not supported.
  assign link_clk = link_sclk ^ serial_clock_invert;

  // Link domain: reset and request synchronisers, load on a new request.
  always_comb begin
    l_nxt = l_r;
    l_nxt.rst_meta = aresetn;
    l_nxt.rst_n = l_r.rst_meta;
    l_nxt.req_meta = a_r.s_req;
    l_nxt.req_sync = l_r.req_meta;
    s_load = l_r.rst_n && (l_r.req_sync != l_r.req_seen);
    if (s_load) begin
      l_nxt.req_seen = l_r.req_sync;
    end
    // The acknowledge returns only when the whole word has left.
    if (!s_if.busy && !s_load) begin
      l_nxt.ack = l_r.req_seen;
    end
    if (!l_r.rst_n) begin
      l_nxt.req_meta = 1'b0;
      l_nxt.req_sync = 1'b0;
      l_nxt.req_seen = 1'b0;
      l_nxt.ack = 1'b0;
    end
  end

  // Link state register.
  always_ff @(posedge link_clk) begin
    l_r <= l_nxt;
  end

  // (R6) Chain input role; it is sampled straight on the serial clock that also clocks it.
  assign s_if.chain_in = shared_in[sport_pkg::PIN_RD_CHAIN];
  assign s_if.load = s_load;
  // (R7) Shifting never stops so chain data follows.
  assign s_if.shift = 1'b1;
  assign s_if.word = a_r.tx_word;

  serial_shifter #(.W(W)) slave_shifter (
    .clk(link_clk),
    .rst_n(l_r.rst_n),
    .sp(s_if)
  );

  // Outputs straight from registers, except the serial data select.
  assign awready = a_r.awready;
  assign wready = a_r.wready;
  assign bvalid = a_r.bvalid;
  assign bresp = a_r.bresp;
  assign arready = a_r.arready;
  assign rvalid = a_r.rvalid;
  assign rdata = a_r.rdata;
  assign rresp = a_r.rresp;
  assign shared_out = a_r.par_out;
  assign shared_oe = a_r.par_oe;
  assign sclk_out = a_r.sclk_out;
  assign sclk_oe = a_r.sclk_oe;
  assign sync_out = a_r.sync_out;
  // (R3) Output follows the external clock.
  assign serial_result_out = clock_source_select ? s_if.dout : m_if.dout;

  // Cycles since the last slave load, only for checking.
  logic [4:0] lcnt;
  always_ff @(posedge link_clk) begin
    if (!l_r.rst_n || s_load) begin
      lcnt <= 5'h0;
    end else if (lcnt != 5'h1f) begin
      lcnt <= lcnt + 5'h1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // The sampled reset keeps the release edge out, since its outputs are still cleared then.
  property p_par_bits;
    (aresetn && !serial) |=> (shared_oe == 4'hf) && (shared_out == $past(a_r.result[9:6]));
  endproperty
  a_par_bits: assert property (p_par_bits) else $error("shared pins not result bits"); // (R1)

  property p_own_clock;
    (serial && !clock_source_select && $stable(a_r.mode)) |=> sclk_oe;
  endproperty
  a_own_clock: assert property (p_own_clock) else $error("master clock not driven"); // (R2)

  property p_ext_clock;
    (serial && clock_source_select) |=> !sclk_oe && (a_r.mst == sport_pkg::M_IDLE);
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("clock driven in slave"); // (R3)

  property p_sync_pol;
    serial |=> sync_out == ($past(sync_active) ^ $past(sync_polarity_select));
  endproperty
  a_sync_pol: assert property (p_sync_pol) else $error("sync polarity wrong"); // (R4)

  property p_clk_inv;
    (serial && !clock_source_select) |=> sclk_out == (a_r.phase ^ $past(serial_clock_invert));
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("serial clock inversion wrong"); // (R5)

  property p_read_role;
    (serial && !clock_source_select && read_mode_or_chain_input && conv_start
      && a_r.mst == sport_pkg::M_IDLE) |=> (a_r.mst == sport_pkg::M_SHIFT) ##1 m_if.busy;
  endproperty
  a_read_role: assert property (p_read_role) else $error("read during conversion missed"); // (R6)

  property p_chain_delay;
    @(posedge link_clk) disable iff (!l_r.rst_n)
      (lcnt == 5'd18) |-> s_if.dout == $past(s_if.chain_in, 18);
  endproperty
  a_chain_delay: assert property (p_chain_delay) else $error("chain delay wrong"); // (R7)

  property p_after_conv;
    (serial && !clock_source_select && !read_mode_or_chain_input && !result_valid
      && a_r.mst == sport_pkg::M_IDLE) |=> (a_r.mst == sport_pkg::M_IDLE);
  endproperty
  a_after_conv: assert property (p_after_conv) else $error("frame before conversion end"); // (R8)

  property p_msb_first;
    m_load |=> m_if.dout == $past(m_word[W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB"); // (R10)

  property p_cov_master;
    a_r.mst == sport_pkg::M_END;
  endproperty
  c_cov_master: cover property (p_cov_master);

  property p_cov_slave;
    $fell(s_pending);
  endproperty
  c_cov_slave: cover property (p_cov_slave);

  property p_cov_parallel;
    !serial && result_valid;
  endproperty
  c_cov_parallel: cover property (p_cov_parallel);
endmodule : adc_serial_port_pin_config
`default_nettype wire

// *** host_link_model.sv ***
// Host side of the serial link: makes the slave clock and captures serial data.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Control from the bench.
  input wire logic run,
  input wire logic master,
  input wire logic inv,
  input wire logic arm,
  // Serial pins.
  input wire logic sclk_pin,
  input wire logic dout,
  output logic host_sclk,
  // Captured bits, the first one at index 0.
  output logic [31:0] cap
);
  logic [5:0] cnt = 6'h0;
  logic cap_clk;
  // host drives clock
  // The clock stands still between frames at the level that keeps the link clock low.
  // Its 7 ns offset keeps its edges away from the system clock edges.
  initial begin
    host_sclk = 1'b0;
    #7;
    forever begin
      #15;
      host_sclk = run ? ~host_sclk : inv;
    end
  end
  // sample opposite edge
  // Slave data is taken on the edge after the update; master data on the rising
  // edge of the uninverted internal clock, as the device shifts on its falling edge.
  assign cap_clk = sclk_pin ^ inv ^ ~master;
  // Bits are stored in arrival order so the bench can compare the first bit to the MSB.
  always @(posedge cap_clk or negedge arm) begin
    if (!arm) begin
      cnt <= 6'h0;
      cap <= 32'h0;
    end else if (cnt < 6'h20) begin
      cap[cnt[4:0]] <= dout;
      cnt <= cnt + 6'h1;
    end
  end
endmodule : host_link_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the shared pin and serial port configuration block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Clock, reset and register bus.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Engine, pins and link.
  logic [17:0] result_data = 18'h0;
  logic result_valid = 1'b0;
  logic conv_start = 1'b0;
  logic [3:0] drv = 4'h0;
  logic [3:0] pins, shared_out, shared_oe;
  logic sclk_pin, sclk_out, sclk_oe, sync_out, sdo, host_sclk;
  logic run = 1'b1;
  logic arm = 1'b0;
  logic [31:0] cap;
  int error_cnt = 0;
  int checks = 0;

  // Each pin carries whichever party has its driver enabled.
  assign pins = (shared_oe & shared_out) | (~shared_oe & drv);
  assign sclk_pin = sclk_oe ? sclk_out : host_sclk;
  always #10 aclk = ~aclk;

  adc_serial_port_pin_config i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .result_data(result_data), .result_valid(result_valid), .conv_start(conv_start),
    .shared_in(pins), .shared_out(shared_out), .shared_oe(shared_oe),
    .link_sclk(sclk_pin), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sync_out(sync_out), .serial_result_out(sdo));

  host_link_model i_host (.run(run), .master(~drv[0]), .inv(drv[2]), .arm(arm),
    .sclk_pin(sclk_pin), .dout(sdo), .host_sclk(host_sclk), .cap(cap));

  // Value comparison, counted and reported at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // An expired wait counts as a mismatch and ends the run.
  task automatic stop_if(input logic c);
    if (c) begin
      error_cnt++;
      $display("ERROR at %0t: timeout, got %h expected %h", $time, 1'b0, 1'b1);
      give_verdict();
    end
  endtask : stop_if

  // Write with address and data offered together; bready stays up until the answer.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    stop_if(n >= 50);
    cmp(32'(bresp), 32'(er));
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    stop_if(n >= 50);
    cmp(rdata, exp);
    cmp(32'(rresp), 32'(er));
  endtask : axi_rd

  // One-cycle pulse of conversion start or of result valid with its data.
  task automatic pulse(input logic cv, input logic [17:0] d);
    @(posedge aclk);
    result_data <= d;
    result_valid <= ~cv;
    conv_start <= cv;
    @(posedge aclk);
    result_valid <= 1'b0;
    conv_start <= 1'b0;
  endtask : pulse

  // The selects pass a two-flop synchroniser, so they are given time to settle.
  task automatic pins_set(input logic [3:0] v);
    @(posedge aclk);
    drv <= v;
    repeat (5) @(posedge aclk);
  endtask : pins_set

  // One serial frame; p holds the chain or read mode, invert, polarity and source.
  task automatic frame(input logic [3:0] p, input logic [17:0] w);
    logic [17:0] r;
    for (int i = 0; i < 18; i++) r[i] = w[17 - i];
    pins_set(p);
    arm <= 1'b1;
    if (p[0]) begin
      pulse(1'b0, w);
      repeat (3) @(posedge aclk);
      cmp(32'(sclk_oe), 32'h0);
      cmp(32'(sync_out), {31'h0, ~p[1]});
      run <= 1'b1;
      repeat (40) @(posedge aclk);
      run <= 1'b0;
      repeat (12) @(posedge aclk);
      cmp(32'(cap[19:2]), 32'(r));
      cmp(32'(cap[23:20]), 32'({4{p[3]}}));
    end else begin
      // A start of the wrong kind comes first and must not open a frame.
      pulse(~p[3], p[3] ? w : ~w);
      pulse(p[3], p[3] ? ~w : w);
      repeat (3) @(posedge aclk);
      cmp(32'(sclk_oe), 32'h1);
      cmp(32'(sync_out), {31'h0, ~p[1]});
      repeat (90) @(posedge aclk);
      cmp(32'(cap[17:0]), 32'(r));
    end
    cmp(32'(sync_out), 32'(p[1]));
    arm <= 1'b0;
  endtask : frame

  // Main sequence: parallel modes, registers, then every serial configuration.
  initial begin
    logic [17:0] w;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp(32'(shared_oe), 32'hf);
    for (int m = 0; m < 3; m++) begin
      w = 18'h2c5a7 ^ 18'(m * 977);
      axi_wr(sport_pkg::ADDR_CTRL, 32'(m), sport_pkg::RESP_OKAY);
      pulse(1'b0, w);
      repeat (2) @(posedge aclk);
      cmp(32'(shared_oe), 32'hf);
      cmp(32'(shared_out), 32'(w[9:6]));
      axi_rd(sport_pkg::ADDR_RESULT, 32'(w), sport_pkg::RESP_OKAY);
      axi_rd(sport_pkg::ADDR_CTRL, 32'(m), sport_pkg::RESP_OKAY);
    end
    axi_wr(sport_pkg::ADDR_CTRL, 32'h3, sport_pkg::RESP_OKAY);
    pins_set(4'ha);
    cmp(32'(shared_oe), 32'h0);
    axi_rd(sport_pkg::ADDR_STATUS, 32'h2b, sport_pkg::RESP_OKAY);
    axi_wr(sport_pkg::ADDR_STATUS, 32'h0, sport_pkg::RESP_OKAY);
    axi_wr(4'hc, 32'h1, sport_pkg::RESP_SLVERR);
    axi_rd(4'hc, 32'h0, sport_pkg::RESP_SLVERR);
    // A write without its low byte lane must leave the mode alone.
    wstrb <= 4'h0;
    axi_wr(sport_pkg::ADDR_CTRL, 32'h0, sport_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(sport_pkg::ADDR_CTRL, 32'h3, sport_pkg::RESP_OKAY);
    for (int i = 0; i < 16; i++) frame(4'(i), 18'h25a3c ^ 18'(i * 4679));
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
